//--- src/dvm_atten_channel.sv
// One channel attenuator: holds the applied code and walks the level.
// Assumes load, code, mute and tick come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

module dvm_atten_channel (
    input  wire logic       clock_i,
    input  wire logic       srst_i,
    input  wire logic       load_i,
    input  wire logic [7:0] code_i,
    input  wire logic       mute_i,
    input  wire logic       tick_i,
    output logic      [7:0] level_o,
    output logic            muted_o
);

    typedef struct packed {
        logic [7:0] target;
        logic [7:0] level;
        logic       muted;
    } dvm_chan_state_type;

    dvm_chan_state_type state_reg;
    dvm_chan_state_type state_next;
    logic [7:0]         goal;

    // ****************************************
    // Level walk
    // ****************************************
    always_comb begin
        state_next = state_reg;
        if (load_i) begin
            // Mute codes collapse to the floor of the walk.
            if (code_i <= dvm_pkg::MUTE_CEIL) begin
                state_next.target = dvm_pkg::LEVEL_FLOOR;
            end else begin
                state_next.target = code_i;
            end
        end
        // Soft mute walks the level down from where it stands to the floor.
        goal = mute_i ? dvm_pkg::LEVEL_FLOOR : state_reg.target;
        if (tick_i) begin
            if (state_reg.level < goal) begin
                state_next.level = state_reg.level + dvm_pkg::LEVEL_STEP;
            end else if (state_reg.level > goal) begin
                state_next.level = state_reg.level - dvm_pkg::LEVEL_STEP;
            end
        end
        state_next.muted = (state_next.level <= dvm_pkg::MUTE_CEIL);
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_reg.target <= dvm_pkg::ATTEN_RESET;
            state_reg.level  <= dvm_pkg::ATTEN_RESET;
            state_reg.muted  <= 1'h0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign level_o = state_reg.level;
    assign muted_o = state_reg.muted;

endmodule // dvm_atten_channel

`default_nettype wire

//--- src/dvm_mode_regs.sv
// Mode-control registers of a stereo audio DAC behind a serial control port.
// Assumes the port pins and the word clock are asynchronous to clock_i.
`timescale 1ns/1ns
`default_nettype none

module dvm_mode_regs (
    input  wire logic       clock_i,
    input  wire logic       srst_i,
    input  wire logic       ctrl_clk_i,
    input  wire logic       ctrl_latch_n_i,
    input  wire logic       ctrl_data_i,
    input  wire logic       word_clk_i,
    input  wire logic       bitstream_mode_i,
    input  wire logic       filter_bypass_mode_i,
    output logic            ctrl_data_o,
    output logic            ctrl_data_oe_n_o,
    output logic      [7:0] left_level_o,
    output logic      [7:0] right_level_o,
    output logic            left_muted_o,
    output logic            right_muted_o,
    output logic      [2:0] audio_format_select_o,
    output logic      [2:0] bypass_format_o,
    output logic      [1:0] deemph_freq_select_o,
    output logic      [1:0] fir_perf_select_o,
    output logic            deemph_enable_o,
    output logic            soft_mute_o,
    output logic      [1:0] atten_rate_select_o,
    output logic      [7:0] output_ctrl_o
);

    // ****************************************
    // State
    // ****************************************
    typedef enum logic {
        DVM_PORT_IDLE  = 1'b0,
        DVM_PORT_FRAME = 1'b1
    } dvm_port_type;

    typedef struct packed {
        logic [2:0]  clk_sync;
        logic [2:0]  lat_sync;
        logic [2:0]  dat_sync;
        logic [2:0]  wck_sync;
        logic        clk_filt;
        logic        lat_filt;
        logic        dat_filt;
        logic        wck_filt;
        dvm_port_type port;
        logic [4:0]  bit_cnt;
        logic [15:0] shreg;
        logic [7:0]  rd_shreg;
        logic        dout;
        logic        dout_oe_n;
        logic [7:0]  left_code;
        logic [7:0]  right_code;
        logic [7:0]  fmt_ctrl;
        logic [7:0]  out_ctrl;
        logic        load_left;
        logic        load_right;
        logic [2:0]  rate_cnt;
        logic        tick;
        logic [2:0]  fmt_out;
        logic [2:0]  bypass_fmt_out;
        logic [1:0]  dmf_out;
        logic [1:0]  fir_out;
        logic        dme_out;
        logic        mute_out;
    } dvm_state_type;

    dvm_state_type state_reg;
    dvm_state_type state_next;
    logic          clk_rise;
    logic          clk_fall;
    logic          wck_rise;
    logic [6:0]    word_idx;
    logic [7:0]    rd_data;
    logic [2:0]    rate_mask;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        state_next = state_reg;

        // Three-stage synchronisers; a change counts once the last two agree.
        state_next.clk_sync = {state_reg.clk_sync[1:0], ctrl_clk_i};
        state_next.lat_sync = {state_reg.lat_sync[1:0], ctrl_latch_n_i};
        state_next.dat_sync = {state_reg.dat_sync[1:0], ctrl_data_i};
        state_next.wck_sync = {state_reg.wck_sync[1:0], word_clk_i};
        if (state_reg.clk_sync[2] == state_reg.clk_sync[1]) begin
            state_next.clk_filt = state_reg.clk_sync[2];
        end
        if (state_reg.lat_sync[2] == state_reg.lat_sync[1]) begin
            state_next.lat_filt = state_reg.lat_sync[2];
        end
        if (state_reg.dat_sync[2] == state_reg.dat_sync[1]) begin
            state_next.dat_filt = state_reg.dat_sync[2];
        end
        if (state_reg.wck_sync[2] == state_reg.wck_sync[1]) begin
            state_next.wck_filt = state_reg.wck_sync[2];
        end
        clk_rise = state_next.clk_filt & ~state_reg.clk_filt;
        clk_fall = ~state_next.clk_filt & state_reg.clk_filt;
        wck_rise = state_next.wck_filt & ~state_reg.wck_filt;

        // Read-back mux; unmapped and read-only indexes answer zero.
        word_idx = state_reg.shreg[dvm_pkg::IDX_W-1:0];
        unique case (word_idx)
            dvm_pkg::IDX_LEFT_ATTEN:  rd_data = state_reg.left_code;
            dvm_pkg::IDX_RIGHT_ATTEN: rd_data = state_reg.right_code;
            dvm_pkg::IDX_FMT_CTRL:    rd_data = state_reg.fmt_ctrl;
            dvm_pkg::IDX_OUT_CTRL:    rd_data = state_reg.out_ctrl;
            default:                  rd_data = dvm_pkg::READ_ZERO;
        endcase

        state_next.load_left  = 1'h0;
        state_next.load_right = 1'h0;

        unique case (state_reg.port)
            DVM_PORT_IDLE: begin
                state_next.dout_oe_n = 1'h1;
                if (!state_next.lat_filt) begin
                    state_next.port    = DVM_PORT_FRAME;
                    state_next.bit_cnt = dvm_pkg::CNT_ZERO;
                end
            end
            DVM_PORT_FRAME: begin
                if (state_next.lat_filt) begin
                    state_next.port      = DVM_PORT_IDLE;
                    state_next.dout_oe_n = 1'h1;
                    // A write lands only for a complete 16-bit word.
                    if (state_reg.bit_cnt == dvm_pkg::CNT_WORD_DONE &&
                        state_reg.shreg[dvm_pkg::RW_BIT] == dvm_pkg::RW_WRITE) begin
                        unique case (state_reg.shreg[dvm_pkg::IDX_HI:dvm_pkg::IDX_LO])
                            dvm_pkg::IDX_LEFT_ATTEN: begin
                                state_next.left_code = state_reg.shreg[7:0];
                                state_next.load_left =
                                    state_reg.fmt_ctrl[dvm_pkg::LOAD_BIT];
                            end
                            dvm_pkg::IDX_RIGHT_ATTEN: begin
                                state_next.right_code = state_reg.shreg[7:0];
                                state_next.load_right =
                                    state_reg.fmt_ctrl[dvm_pkg::LOAD_BIT];
                            end
                            dvm_pkg::IDX_FMT_CTRL: begin
                                state_next.fmt_ctrl = state_reg.shreg[7:0];
                            end
                            dvm_pkg::IDX_OUT_CTRL: begin
                                state_next.out_ctrl = state_reg.shreg[7:0];
                            end
                            default: begin
                                // Read-only and unmapped indexes drop writes.
                                state_next.out_ctrl = state_reg.out_ctrl;
                            end
                        endcase
                    end
                end else if (clk_rise &&
                             state_reg.bit_cnt != dvm_pkg::CNT_WORD_DONE) begin
                    state_next.shreg = {state_reg.shreg[14:0],
                                        state_reg.dat_filt};
                    state_next.bit_cnt = state_reg.bit_cnt + dvm_pkg::CNT_ONE;
                end else if (clk_fall &&
                             state_reg.bit_cnt == dvm_pkg::CNT_IDX_DONE &&
                             state_reg.shreg[7] == dvm_pkg::RW_READ) begin
                    // Flag and index are in; start driving read data.
                    state_next.dout      = rd_data[7];
                    state_next.rd_shreg  = {rd_data[6:0], 1'h0};
                    state_next.dout_oe_n = 1'h0;
                end else if (clk_fall && !state_reg.dout_oe_n &&
                             state_reg.bit_cnt > dvm_pkg::CNT_IDX_DONE) begin
                    state_next.dout     = state_reg.rd_shreg[7];
                    state_next.rd_shreg = {state_reg.rd_shreg[6:0], 1'h0};
                end
            end
        endcase

        // Attenuation step tick: word clock divided by 1, 2, 4 or 8.
        unique case (dvm_pkg::dvm_rate_type'(
                     state_reg.out_ctrl[dvm_pkg::ATS_HI:dvm_pkg::ATS_LO]))
            dvm_pkg::DVM_RATE_DIV1: rate_mask = dvm_pkg::RATE_MASK1;
            dvm_pkg::DVM_RATE_DIV2: rate_mask = dvm_pkg::RATE_MASK2;
            dvm_pkg::DVM_RATE_DIV4: rate_mask = dvm_pkg::RATE_MASK4;
            dvm_pkg::DVM_RATE_DIV8: rate_mask = dvm_pkg::RATE_MASK8;
        endcase
        state_next.tick = 1'h0;
        if (wck_rise) begin
            state_next.rate_cnt = state_reg.rate_cnt + dvm_pkg::RATE_STEP;
            state_next.tick = ((state_reg.rate_cnt & rate_mask) == rate_mask);
        end

        // Format field: normal encodings, or the bypass meaning.
        if (filter_bypass_mode_i) begin
            state_next.bypass_fmt_out =
                state_reg.fmt_ctrl[dvm_pkg::FMT_HI:dvm_pkg::FMT_LO];
            state_next.fmt_out = state_reg.fmt_out;
        end else begin
            state_next.fmt_out =
                state_reg.fmt_ctrl[dvm_pkg::FMT_HI:dvm_pkg::FMT_LO];
        end

        // De-emphasis field: rate, or output filter setting in bitstream mode.
        if (bitstream_mode_i) begin
            state_next.fir_out =
                state_reg.fmt_ctrl[dvm_pkg::DMF_HI:dvm_pkg::DMF_LO];
            state_next.dme_out = 1'h0;
        end else begin
            state_next.dmf_out =
                state_reg.fmt_ctrl[dvm_pkg::DMF_HI:dvm_pkg::DMF_LO];
            state_next.dme_out = state_reg.fmt_ctrl[dvm_pkg::DME_BIT];
        end
        state_next.mute_out = state_reg.fmt_ctrl[dvm_pkg::MUTE_BIT];
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_reg            <= '0;
            // Clock and latch pins idle high; seeding their filters there avoids a false edge.
            state_reg.clk_sync   <= 3'h7;
            state_reg.clk_filt   <= 1'h1;
            state_reg.lat_sync   <= 3'h7;
            state_reg.lat_filt   <= 1'h1;
            state_reg.dout_oe_n  <= 1'h1;
            state_reg.left_code  <= dvm_pkg::ATTEN_RESET;
            state_reg.right_code <= dvm_pkg::ATTEN_RESET;
            state_reg.fmt_ctrl   <= dvm_pkg::FMT_CTRL_RESET;
            state_reg.out_ctrl   <= dvm_pkg::OUT_CTRL_RESET;
            state_reg.fmt_out    <= dvm_pkg::DVM_FMT_I2S24;
            state_reg.dmf_out    <= dvm_pkg::DVM_DMF_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Attenuators
    // ****************************************
    // Both channels share one tick and one soft-mute level.
    dvm_atten_channel u_left (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .load_i  (state_reg.load_left),
        .code_i  (state_reg.left_code),
        .mute_i  (state_reg.mute_out),
        .tick_i  (state_reg.tick),
        .level_o (left_level_o),
        .muted_o (left_muted_o)
    );

    dvm_atten_channel u_right (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .load_i  (state_reg.load_right),
        .code_i  (state_reg.right_code),
        .mute_i  (state_reg.mute_out),
        .tick_i  (state_reg.tick),
        .level_o (right_level_o),
        .muted_o (right_muted_o)
    );

    // ****************************************
    // Outputs
    // ****************************************
    assign ctrl_data_o           = state_reg.dout;
    assign ctrl_data_oe_n_o      = state_reg.dout_oe_n;
    assign audio_format_select_o = state_reg.fmt_out;
    assign bypass_format_o       = state_reg.bypass_fmt_out;
    assign deemph_freq_select_o  = state_reg.dmf_out;
    assign fir_perf_select_o     = state_reg.fir_out;
    assign deemph_enable_o       = state_reg.dme_out;
    assign soft_mute_o           = state_reg.mute_out;
    assign atten_rate_select_o   =
        state_reg.out_ctrl[dvm_pkg::ATS_HI:dvm_pkg::ATS_LO];
    assign output_ctrl_o         = state_reg.out_ctrl;

endmodule // dvm_mode_regs

`default_nettype wire

//--- src/dvm_pkg.sv
// Constants shared by the DAC mode-control register block.
// Assumes a single 50 MHz system clock and a synchronous active-high reset.
package dvm_pkg;

    // ****************************************
    // Control word layout
    // ****************************************
    localparam int WORD_W  = 16;
    localparam int DATA_W  = 8;
    localparam int IDX_W   = 7;
    localparam int CNT_W   = 5;
    localparam int RW_BIT  = 15;
    localparam int IDX_HI  = 14;
    localparam int IDX_LO  = 8;
    localparam logic             RW_WRITE      = 1'h0;
    localparam logic             RW_READ       = 1'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO      = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE       = 5'h01;
    localparam logic [CNT_W-1:0] CNT_IDX_DONE  = 5'h08;
    localparam logic [CNT_W-1:0] CNT_WORD_DONE = 5'h10;

    // ****************************************
    // Register indexes and reset values
    // ****************************************
    localparam logic [IDX_W-1:0]  IDX_LEFT_ATTEN  = 7'h10;
    localparam logic [IDX_W-1:0]  IDX_RIGHT_ATTEN = 7'h11;
    localparam logic [IDX_W-1:0]  IDX_FMT_CTRL    = 7'h12;
    localparam logic [IDX_W-1:0]  IDX_OUT_CTRL    = 7'h13;
    localparam logic [DATA_W-1:0] ATTEN_RESET     = 8'hFF;
    localparam logic [DATA_W-1:0] FMT_CTRL_RESET  = 8'h50;
    localparam logic [DATA_W-1:0] OUT_CTRL_RESET  = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO       = 8'h00;

    // Codes at or below this ceiling mean full mute.
    localparam logic [DATA_W-1:0] MUTE_CEIL   = 8'h0E;
    localparam logic [DATA_W-1:0] LEVEL_FLOOR = 8'h00;
    localparam logic [DATA_W-1:0] LEVEL_STEP  = 8'h01;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int LOAD_BIT = 7;
    localparam int FMT_HI   = 6;
    localparam int FMT_LO   = 4;
    localparam int DMF_HI   = 3;
    localparam int DMF_LO   = 2;
    localparam int DME_BIT  = 1;
    localparam int MUTE_BIT = 0;
    localparam int ATS_HI   = 6;
    localparam int ATS_LO   = 5;

    // ****************************************
    // Field encodings
    // ****************************************
    typedef enum logic [2:0] {
        DVM_FMT_RJ16  = 3'h0,
        DVM_FMT_RJ20  = 3'h1,
        DVM_FMT_RJ24  = 3'h2,
        DVM_FMT_LJ24  = 3'h3,
        DVM_FMT_I2S16 = 3'h4,
        DVM_FMT_I2S24 = 3'h5,
        DVM_FMT_RSV6  = 3'h6,
        DVM_FMT_RSV7  = 3'h7
    } dvm_format_type;

    typedef enum logic [1:0] {
        DVM_DMF_OFF  = 2'h0,
        DVM_DMF_48K  = 2'h1,
        DVM_DMF_441K = 2'h2,
        DVM_DMF_32K  = 2'h3
    } dvm_deemph_type;

    typedef enum logic [1:0] {
        DVM_RATE_DIV1 = 2'h0,
        DVM_RATE_DIV2 = 2'h1,
        DVM_RATE_DIV4 = 2'h2,
        DVM_RATE_DIV8 = 2'h3
    } dvm_rate_type;

    localparam int RATE_CNT_W = 3;
    localparam logic [RATE_CNT_W-1:0] RATE_MASK1 = 3'h0;
    localparam logic [RATE_CNT_W-1:0] RATE_MASK2 = 3'h1;
    localparam logic [RATE_CNT_W-1:0] RATE_MASK4 = 3'h3;
    localparam logic [RATE_CNT_W-1:0] RATE_MASK8 = 3'h7;
    localparam logic [RATE_CNT_W-1:0] RATE_STEP  = 3'h1;

endpackage

//--- verification/dvm_host_model.sv
// Host controller model for the serial control port.
// Assumes clock_i is the system clock; pins change on its falling edge.
`timescale 1ns/1ns
`default_nettype none

module dvm_host_model (
    input  wire logic clock_i,
    input  wire logic dev_data_i,
    input  wire logic dev_oe_n_i,
    output var  logic ctrl_clk_o,
    output var  logic ctrl_latch_n_o,
    output var  logic ctrl_data_o
);
    logic tog = 1'b0;
    logic rd_wire;

    // An undriven return line toggles each cycle, but samples 16 cycles apart all see the same value.
    always @(negedge clock_i) tog <= ~tog;
    assign rd_wire = dev_oe_n_i ? tog : dev_data_i;

    initial begin
        ctrl_clk_o = 1'b1;
        ctrl_latch_n_o = 1'b1;
        ctrl_data_o = 1'b0;
    end

    task automatic xfer(input logic [15:0] word, output logic [7:0] rd);
        int b;
        @(negedge clock_i) ctrl_latch_n_o = 1'b0;
        repeat (8) @(negedge clock_i);
        for (b = 15; b >= 0; b--) begin
            ctrl_clk_o = 1'b0;
            ctrl_data_o = word[b];
            repeat (8) @(negedge clock_i);
            ctrl_clk_o = 1'b1;
            if (b < 8) rd[b] = rd_wire;
            repeat (8) @(negedge clock_i);
        end
        ctrl_latch_n_o = 1'b1;
        ctrl_data_o = ~ctrl_data_o;
        repeat (8) @(negedge clock_i);
    endtask
endmodule // dvm_host_model
`default_nettype wire

//--- verification/dvm_mode_regs_props.sv
// Checker for the DAC mode-control register block.
// Assumes it is bound to dvm_mode_regs and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none

module dvm_mode_regs_props (
    input wire logic       clock_i,
    input wire logic       srst_i,
    input wire logic       ctrl_latch_n_i,
    input wire logic       bitstream_mode_i,
    input wire logic       filter_bypass_mode_i,
    input wire logic       ctrl_data_oe_n_o,
    input wire logic [7:0] left_level_o,
    input wire logic [7:0] right_level_o,
    input wire logic       left_muted_o,
    input wire logic       right_muted_o,
    input wire logic [2:0] audio_format_select_o,
    input wire logic [1:0] deemph_freq_select_o,
    input wire logic       deemph_enable_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    // ****************************************
    // Port, attenuator and mode-field properties
    // ****************************************
    sequence s_latch_idle;
        ctrl_latch_n_i [*8];
    endsequence
    property p_oe_idle;
        s_latch_idle |-> ctrl_data_oe_n_o;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("read driver on outside frame");
    property p_rst;
        $fell(srst_i) |-> left_level_o == 8'hFF && right_level_o == 8'hFF
            && audio_format_select_o == 3'h5 && deemph_freq_select_o == 2'h0
            && !deemph_enable_o && ctrl_data_oe_n_o;
    endproperty
    a_rst: assert property (p_rst) else $error("wrong value after reset");
    property p_lmute;
        $stable(left_level_o) |-> left_muted_o == (left_level_o <= 8'h0E);
    endproperty
    a_lmute: assert property (p_lmute) else $error("left mute flag wrong");
    property p_rmute;
        $stable(right_level_o) |-> right_muted_o == (right_level_o <= 8'h0E);
    endproperty
    a_rmute: assert property (p_rmute) else $error("right mute flag wrong");
    sequence s_one_step;
        left_level_o - $past(left_level_o) == 8'h01
            || $past(left_level_o) - left_level_o == 8'h01;
    endsequence
    property p_lstep;
        !$past(srst_i) && $changed(left_level_o) |-> s_one_step ##1 $stable(left_level_o);
    endproperty
    a_lstep: assert property (p_lstep) else $error("left level jumped");
    property p_fmt_hold;
        filter_bypass_mode_i [*3] |-> $stable(audio_format_select_o);
    endproperty
    a_fmt_hold: assert property (p_fmt_hold) else $error("format moved in bypass");
    property p_dme_bs;
        bitstream_mode_i [*2] |-> !deemph_enable_o;
    endproperty
    a_dme_bs: assert property (p_dme_bs) else $error("de-emphasis on in bitstream");
    property p_dmf_hold;
        bitstream_mode_i [*3] |-> $stable(deemph_freq_select_o);
    endproperty
    a_dmf_hold: assert property (p_dmf_hold) else $error("rate moved in bitstream");
endmodule // dvm_mode_regs_props

bind dvm_mode_regs dvm_mode_regs_props u_props (
    .clock_i, .srst_i, .ctrl_latch_n_i, .bitstream_mode_i, .filter_bypass_mode_i,
    .ctrl_data_oe_n_o, .left_level_o, .right_level_o, .left_muted_o,
    .right_muted_o, .audio_format_select_o, .deemph_freq_select_o, .deemph_enable_o
);
`default_nettype wire

//--- verification/dvm_mode_regs_tb_top.sv
// Self-checking bench for the DAC mode-control register block.
// Assumes the package, design, host model and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none

module dvm_mode_regs_tb_top;
    logic       clock_i = 1'b0;
    logic       srst_i = 1'b1;
    logic       word_clk_i = 1'b0;
    logic       bitstream_mode_i = 1'b0;
    logic       filter_bypass_mode_i = 1'b0;
    logic       ctrl_clk_i, ctrl_latch_n_i, ctrl_data_i, ctrl_data_o;
    logic       ctrl_data_oe_n_o, left_muted_o, right_muted_o;
    logic       deemph_enable_o, soft_mute_o;
    logic [7:0] left_level_o, right_level_o, output_ctrl_o;
    logic [2:0] audio_format_select_o, bypass_format_o;
    logic [1:0] deemph_freq_select_o, fir_perf_select_o, atten_rate_select_o;
    int         err_total = 0;
    int         tests_run = 0;

    dvm_mode_regs dut (
        .clock_i, .srst_i, .ctrl_clk_i, .ctrl_latch_n_i, .ctrl_data_i,
        .word_clk_i, .bitstream_mode_i, .filter_bypass_mode_i, .ctrl_data_o,
        .ctrl_data_oe_n_o, .left_level_o, .right_level_o, .left_muted_o,
        .right_muted_o, .audio_format_select_o, .bypass_format_o,
        .deemph_freq_select_o, .fir_perf_select_o, .deemph_enable_o,
        .soft_mute_o, .atten_rate_select_o, .output_ctrl_o
    );
    dvm_host_model host (
        .clock_i, .dev_data_i(ctrl_data_o), .dev_oe_n_i(ctrl_data_oe_n_o),
        .ctrl_clk_o(ctrl_clk_i), .ctrl_latch_n_o(ctrl_latch_n_i),
        .ctrl_data_o(ctrl_data_i)
    );

    // ****************************************
    // Clocks, helpers and scenarios
    // ****************************************
    initial begin
        forever #10 clock_i = ~clock_i;
    end
    // Word clock of 40 system clocks, free running and unrelated to frames.
    always begin
        repeat (20) @(negedge clock_i);
        word_clk_i <= ~word_clk_i;
    end

    task automatic stop_test;
        $display("comparisons=%0d mismatches=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        logic [7:0] junk;
        host.xfer({dvm_pkg::RW_WRITE, idx, d}, junk);
    endtask
    task automatic rdchk(input logic [6:0] idx, input logic [7:0] exp);
        logic [7:0] got;
        host.xfer({dvm_pkg::RW_READ, idx, 8'hA5}, got);
        chk(got, exp);
    endtask
    task automatic edges(input int n);
        repeat (n) @(posedge word_clk_i);
        @(negedge clock_i);
    endtask
    task automatic do_reset(input int n);
        srst_i = 1'b1;
        repeat (n) @(negedge clock_i);
        srst_i = 1'b0;
    endtask

    task automatic t_reset;
        rdchk(7'h10, 8'hFF);
        rdchk(7'h11, 8'hFF);
        rdchk(7'h12, 8'h50);
        rdchk(7'h13, 8'h00);
        chk({5'h00, audio_format_select_o}, 8'h05);
    endtask
    task automatic t_noload;
        wr(7'h10, 8'h80);
        rdchk(7'h10, 8'h80);
        edges(4);
        chk(left_level_o, 8'hFF);
    endtask
    task automatic t_load;
        wr(7'h12, 8'hD0);
        wr(7'h10, 8'h20);
        wr(7'h11, 8'h05);
        edges(260);
        chk(left_level_o, 8'h20);
        chk(right_level_o, 8'h00);
        chk({6'h00, right_muted_o, left_muted_o}, 8'h02);
    endtask
    task automatic t_rate;
        logic [7:0] t;
        for (int r = 0; r < 4; r++) begin
            t = 8'h22 + 8'(2 * r);
            wr(7'h13, {1'b0, 2'(r), 5'h00});
            chk({6'h00, atten_rate_select_o}, 8'(r));
            wr(7'h10, t);
            edges((1 << r) - 1);
            chk({7'h00, left_level_o === t}, 8'h00);
            edges(2 * (1 << r) + 1);
            chk(left_level_o, t);
        end
    endtask
    task automatic t_mute;
        wr(7'h12, 8'hD1);
        chk({7'h00, soft_mute_o}, 8'h01);
        edges(330);
        chk({left_level_o[6:0], left_muted_o}, 8'h01);
        wr(7'h12, 8'hD0);
        edges(16);
        chk({soft_mute_o, 6'h00, left_level_o === 8'h00}, 8'h00);
    endtask
    task automatic t_fmt;
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            v = {1'b0, 3'(i), 2'(i), 1'(i), 1'b0};
            wr(7'h12, v);
            chk({5'h00, audio_format_select_o}, 8'(i));
            chk({5'h00, deemph_freq_select_o, deemph_enable_o},
                {5'h00, 2'(i), 1'(i)});
            rdchk(7'h12, v);
        end
    endtask
    task automatic t_modes;
        bitstream_mode_i = 1'b1;
        wr(7'h12, 8'h5A);
        chk({fir_perf_select_o, deemph_freq_select_o, 3'h0, deemph_enable_o}, 8'hB0);
        bitstream_mode_i = 1'b0;
        filter_bypass_mode_i = 1'b1;
        wr(7'h12, 8'h30);
        chk({bypass_format_o, 2'h0, audio_format_select_o}, 8'h65);
        filter_bypass_mode_i = 1'b0;
    endtask
    task automatic t_unmapped;
        wr(7'h16, 8'h55);
        rdchk(7'h16, 8'h00);
        rdchk(7'h13, 8'h60);
        chk(output_ctrl_o, 8'h60);
    endtask

    initial begin
        // The scenarios need roughly 40,000 cycles; allow about 60,000.
        #1200000;
        err_total++;
        stop_test();
    end
    initial begin
        do_reset(4);
        t_reset();
        t_noload();
        t_load();
        t_rate();
        t_mute();
        t_fmt();
        t_modes();
        t_unmapped();
        do_reset(2);
        t_reset();
        stop_test();
    end
endmodule // dvm_mode_regs_tb_top
`default_nettype wire
